// file: hdl/fxst_pkg.sv
// Package of register map, field layouts and carrier types for the flag bank.
package fxst_pkg;

  // ---------------------------------------------------------------------------
  // Register map and layout
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;
  localparam int          NUM_SHIFTERS      = 4;
  localparam int          NUM_TIMERS        = 4;
  localparam int          NUM_PINS          = 8;
  localparam int          CNT_W             = 16;
  localparam int          CNT_HI_LSB        = 8;
  localparam logic [7:0]  OFS_PIN_LEVELS    = 8'h04;
  localparam logic [7:0]  OFS_SHIFTER_READY = 8'h08;
  localparam logic [7:0]  OFS_SHIFTER_FAULT = 8'h0C;
  localparam logic [7:0]  OFS_TIMER_EXPIRY  = 8'h10;
  localparam logic [7:0]  OFS_READY_IRQ_EN  = 8'h18;
  localparam logic [7:0]  OFS_FAULT_IRQ_EN  = 8'h1C;
  localparam logic [7:0]  OFS_EXPIRY_IRQ_EN = 8'h20;
  localparam logic [7:0]  OFS_READY_DMA_EN  = 8'h28;
  localparam logic [3:0]  FLAG_RESET        = 4'h0;
  localparam logic [3:0]  ENABLE_RESET      = 4'h0;
  localparam logic [3:0]  FULL_WORD_STRB    = 4'hF;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ---------------------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FXST_SMODE_OFF = 3'b000,
    FXST_SMODE_RX  = 3'b001,
    FXST_SMODE_TX  = 3'b010
  } fxst_shifter_mode_sel_t;

  typedef enum logic [1:0] {
    FXST_TMODE_OFF    = 2'b00,
    FXST_TMODE_BAUD8  = 2'b01,
    FXST_TMODE_PWM8   = 2'b10,
    FXST_TMODE_CNT16  = 2'b11
  } fxst_timer_mode_t;

  typedef enum logic [3:0] {
    FXST_REG_NONE   = 4'h0,
    FXST_REG_PINS   = 4'h1,
    FXST_REG_READY  = 4'h2,
    FXST_REG_FAULT  = 4'h3,
    FXST_REG_EXPIRY = 4'h4,
    FXST_REG_RIEN   = 4'h5,
    FXST_REG_FIEN   = 4'h6,
    FXST_REG_EIEN   = 4'h7,
    FXST_REG_RDMA   = 4'h8
  } fxst_reg_sel_t;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    fxst_shifter_mode_sel_t shifter_mode_sel;
    logic                   buf_loaded;
    logic                   buf_to_shifter;
    logic                   buf_read;
    logic                   buf_written;
    logic                   overrun;
    logic                   frame_mismatch;
    logic                   underrun;
  } fxst_shifter_evt_t;

  typedef struct packed {
    fxst_timer_mode_t       mode;
    logic                   dec_active;
    logic [CNT_W-1:0]       count;
  } fxst_timer_evt_t;

  // Maps a byte address onto a register; non-word-aligned addresses map to none.
  function automatic fxst_reg_sel_t fxst_decode(input logic [ADDR_W-1:0] addr);
    fxst_reg_sel_t sel;
    sel = FXST_REG_NONE;
    unique case (addr)
      OFS_PIN_LEVELS:    sel = FXST_REG_PINS;
      OFS_SHIFTER_READY: sel = FXST_REG_READY;
      OFS_SHIFTER_FAULT: sel = FXST_REG_FAULT;
      OFS_TIMER_EXPIRY:  sel = FXST_REG_EXPIRY;
      OFS_READY_IRQ_EN:  sel = FXST_REG_RIEN;
      OFS_FAULT_IRQ_EN:  sel = FXST_REG_FIEN;
      OFS_EXPIRY_IRQ_EN: sel = FXST_REG_EIEN;
      OFS_READY_DMA_EN:  sel = FXST_REG_RDMA;
      default:           sel = FXST_REG_NONE;
    endcase
    return sel;
  endfunction

endpackage

// file: hdl/fxst_flag_bank.sv
// Sticky flag bank: hardware sets, clears from software or hardware events, set wins over clear.
`timescale 1ns/100ps

module fxst_flag_bank #(
  parameter int WIDTH = 4
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic [WIDTH-1:0] i_clr,
  output logic      [WIDTH-1:0] o_flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  initial begin
    if (WIDTH < 1 || WIDTH > 32) begin
      $error("fxst_flag_bank: WIDTH must lie between 1 and 32.");
    end
  end

  // A clear in the same cycle as a set leaves the flag set.
  assign flags_next = (flags_reg & ~i_clr) | i_set;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign o_flags = flags_reg;

endmodule

// file: hdl/fxst_status_regs.sv
// Status flags, pin levels and enable registers of the flexible I/O unit on AXI4-Lite.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps

module fxst_status_regs #(
  parameter int NUM_PINS = fxst_pkg::NUM_PINS
) (
  input  wire logic                                     i_ref_clk,
  input  wire logic                                     i_rst_b,
  input  wire logic [NUM_PINS-1:0]                      i_pin_level_bits,
  input  wire fxst_pkg::fxst_shifter_evt_t [3:0]        i_shifter,
  input  wire fxst_pkg::fxst_timer_evt_t   [3:0]        i_timer,
  input  wire logic                                     i_awvalid,
  output logic                                          o_awready,
  input  wire logic [fxst_pkg::ADDR_W-1:0]              i_awaddr,
  input  wire logic [2:0]                               i_awprot,
  input  wire logic                                     i_wvalid,
  output logic                                          o_wready,
  input  wire logic [fxst_pkg::DATA_W-1:0]              i_wdata,
  input  wire logic [3:0]                               i_wstrb,
  output logic                                          o_bvalid,
  input  wire logic                                     i_bready,
  output logic [1:0]                                    o_bresp,
  input  wire logic                                     i_arvalid,
  output logic                                          o_arready,
  input  wire logic [fxst_pkg::ADDR_W-1:0]              i_araddr,
  input  wire logic [2:0]                               i_arprot,
  output logic                                          o_rvalid,
  input  wire logic                                     i_rready,
  output logic [fxst_pkg::DATA_W-1:0]                   o_rdata,
  output logic [1:0]                                    o_rresp,
  output logic                                          o_irq,
  output logic [3:0]                                    o_dma_req
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic                          awready_reg;
  logic                          wready_reg;
  logic                          bvalid_reg;
  logic [1:0]                    bresp_reg;
  logic                          arready_reg;
  logic                          rvalid_reg;
  logic [fxst_pkg::DATA_W-1:0]   rdata_reg;
  logic [1:0]                    rresp_reg;
  logic [fxst_pkg::ADDR_W-1:0]   waddr_reg;
  logic [fxst_pkg::DATA_W-1:0]   wdata_reg;
  logic [3:0]                    wstrb_reg;
  logic                          irq_reg;
  logic [3:0]                    dma_req_reg;
  logic [NUM_PINS-1:0]           pin_levels_reg;
  logic [3:0]                    ready_irq_en_reg;
  logic [3:0]                    fault_irq_en_reg;
  logic [3:0]                    expiry_irq_en_reg;
  logic [3:0]                    ready_dma_en_reg;
  logic [3:0]                    tx_mode_prev_reg;
  logic [3:0]                    timer_zero_prev_reg;
  logic                          wr_fire;
  logic                          wr_ok;
  fxst_pkg::fxst_reg_sel_t       wr_sel;
  fxst_pkg::fxst_reg_sel_t       rd_sel;
  logic [3:0]                    wr_bits;
  logic [3:0]                    ready_set;
  logic [3:0]                    ready_clr;
  logic [3:0]                    fault_set;
  logic [3:0]                    fault_clr;
  logic [3:0]                    expiry_set;
  logic [3:0]                    expiry_clr;
  logic [3:0]                    timer_zero;
  logic [3:0]                    is_rx;
  logic [3:0]                    is_tx;
  logic [3:0]                    ready_flags;
  logic [3:0]                    fault_flags;
  logic [3:0]                    expiry_flags;
  logic [fxst_pkg::DATA_W-1:0]   rdata_next;

  initial begin
    if (NUM_PINS < 1 || NUM_PINS > fxst_pkg::DATA_W) begin
      $error("fxst_status_regs: NUM_PINS must lie between 1 and 32.");
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  // Address and data are held until both have arrived; the write then takes
  // effect on the next edge, the same edge on which the response is raised.
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_sel  = fxst_pkg::fxst_decode(waddr_reg);
  // Only full-word writes to mapped registers take effect; others get SLVERR.
  assign wr_ok   = (wr_sel != fxst_pkg::FXST_REG_NONE)
                && (wstrb_reg == fxst_pkg::FULL_WORD_STRB);
  assign wr_bits = wdata_reg[3:0];

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      awready_reg <= 1'b1;
      waddr_reg   <= '0;
    end else if (awready_reg && i_awvalid) begin
      awready_reg <= 1'b0;
      waddr_reg   <= i_awaddr;
    end else if (bvalid_reg && i_bready) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wready_reg <= 1'b1;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (wready_reg && i_wvalid) begin
      wready_reg <= 1'b0;
      wdata_reg  <= i_wdata;
      wstrb_reg  <= i_wstrb;
    end else if (bvalid_reg && i_bready) begin
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= fxst_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? fxst_pkg::RESP_OKAY : fxst_pkg::RESP_SLVERR;
    end else if (bvalid_reg && i_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Enable registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ready_irq_en_reg  <= fxst_pkg::ENABLE_RESET;
      fault_irq_en_reg  <= fxst_pkg::ENABLE_RESET;
      expiry_irq_en_reg <= fxst_pkg::ENABLE_RESET;
      ready_dma_en_reg  <= fxst_pkg::ENABLE_RESET;
    end else if (wr_fire && wr_ok) begin
      unique case (wr_sel)
        fxst_pkg::FXST_REG_RIEN: ready_irq_en_reg  <= wr_bits;
        fxst_pkg::FXST_REG_FIEN: fault_irq_en_reg  <= wr_bits;
        fxst_pkg::FXST_REG_EIEN: expiry_irq_en_reg <= wr_bits;
        fxst_pkg::FXST_REG_RDMA: ready_dma_en_reg  <= wr_bits;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Flag set and clear conditions
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      is_rx[i] = (i_shifter[i].shifter_mode_sel == fxst_pkg::FXST_SMODE_RX);
      is_tx[i] = (i_shifter[i].shifter_mode_sel == fxst_pkg::FXST_SMODE_TX);
      ready_set[i] = (is_rx[i] && i_shifter[i].buf_loaded)
                  || (is_tx[i] && (i_shifter[i].buf_to_shifter
                                   || !tx_mode_prev_reg[i]));
      ready_clr[i] = (is_rx[i] && i_shifter[i].buf_read)
                  || (is_tx[i] && i_shifter[i].buf_written);
      fault_set[i] = (is_rx[i] && (i_shifter[i].overrun
                                   || i_shifter[i].frame_mismatch))
                  || (is_tx[i] && i_shifter[i].underrun);
      unique case (i_timer[i].mode)
        fxst_pkg::FXST_TMODE_BAUD8,
        fxst_pkg::FXST_TMODE_PWM8:
          timer_zero[i] = (i_timer[i].count[fxst_pkg::CNT_W-1:fxst_pkg::CNT_HI_LSB] == '0);
        fxst_pkg::FXST_TMODE_CNT16:
          timer_zero[i] = (i_timer[i].count == '0);
        fxst_pkg::FXST_TMODE_OFF:
          timer_zero[i] = 1'b0;
      endcase
      // Only the arrival at zero counts, so a cleared flag stays clear while
      // the counter rests there.
      expiry_set[i] = i_timer[i].dec_active && timer_zero[i]
                   && !timer_zero_prev_reg[i];
    end
  end

  // Write-one clears; zero bits in the written word leave flags alone.
  assign fault_clr  = (wr_fire && wr_ok && wr_sel == fxst_pkg::FXST_REG_FAULT)
                    ? wr_bits : 4'h0;
  assign expiry_clr = (wr_fire && wr_ok && wr_sel == fxst_pkg::FXST_REG_EXPIRY)
                    ? wr_bits : 4'h0;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_mode_prev_reg    <= 4'hF;
      timer_zero_prev_reg <= 4'h0;
    end else begin
      tx_mode_prev_reg    <= is_tx;
      timer_zero_prev_reg <= timer_zero;
    end
  end

  // ---------------------------------------------------------------------------
  // Flag banks
  // ---------------------------------------------------------------------------
  fxst_flag_bank #(.WIDTH(4)) u_ready_flags (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_set     (ready_set),
    .i_clr     (ready_clr | ((wr_fire && wr_ok && wr_sel == fxst_pkg::FXST_REG_READY)
                             ? wr_bits : 4'h0)),
    .o_flags   (ready_flags)
  );

  fxst_flag_bank #(.WIDTH(4)) u_fault_flags (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_set     (fault_set),
    .i_clr     (fault_clr),
    .o_flags   (fault_flags)
  );

  fxst_flag_bank #(.WIDTH(4)) u_expiry_flags (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_set     (expiry_set),
    .i_clr     (expiry_clr),
    .o_flags   (expiry_flags)
  );

  // ---------------------------------------------------------------------------
  // Pin levels, interrupt and DMA requests
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_levels_reg <= '0;
    end else begin
      pin_levels_reg <= i_pin_level_bits;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(ready_flags & ready_irq_en_reg)
              || |(fault_flags & fault_irq_en_reg)
              || |(expiry_flags & expiry_irq_en_reg);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dma_req_reg <= 4'h0;
    end else begin
      dma_req_reg <= ready_flags & ready_dma_en_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  assign rd_sel = fxst_pkg::fxst_decode(i_araddr);

  always_comb begin
    rdata_next = '0;
    unique case (rd_sel)
      fxst_pkg::FXST_REG_PINS:   rdata_next[NUM_PINS-1:0] = pin_levels_reg;
      fxst_pkg::FXST_REG_READY:  rdata_next[3:0] = ready_flags;
      fxst_pkg::FXST_REG_FAULT:  rdata_next[3:0] = fault_flags;
      fxst_pkg::FXST_REG_EXPIRY: rdata_next[3:0] = expiry_flags;
      fxst_pkg::FXST_REG_RIEN:   rdata_next[3:0] = ready_irq_en_reg;
      fxst_pkg::FXST_REG_FIEN:   rdata_next[3:0] = fault_irq_en_reg;
      fxst_pkg::FXST_REG_EIEN:   rdata_next[3:0] = expiry_irq_en_reg;
      fxst_pkg::FXST_REG_RDMA:   rdata_next[3:0] = ready_dma_en_reg;
      default:                   rdata_next = '0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= fxst_pkg::RESP_OKAY;
    end else if (arready_reg && i_arvalid) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rdata_next;
      rresp_reg   <= (rd_sel == fxst_pkg::FXST_REG_NONE)
                   ? fxst_pkg::RESP_SLVERR : fxst_pkg::RESP_OKAY;
    end else if (rvalid_reg && i_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_awready = awready_reg;
  assign o_wready  = wready_reg;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid  = rvalid_reg;
  assign o_rdata   = rdata_reg;
  assign o_rresp   = rresp_reg;
  assign o_irq     = irq_reg;
  assign o_dma_req = dma_req_reg;

endmodule

// file: verif/fxst_status_regs_checker.sv
// Checker of the register bus answers of the status flag bank.
`timescale 1ns/100ps

module fxst_status_regs_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [3:0]  i_wstrb,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  o_bresp,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [7:0]  i_araddr,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  property p_rd_lat; i_arvalid && o_arready |=> o_rvalid && !o_arready; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_rd_done; o_rvalid && i_rready |=> !o_rvalid && o_arready; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read not retired");
  property p_unmap; i_arvalid && o_arready && i_araddr == 8'h00 |=> o_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_b_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_done; o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready; endproperty
  a_b_done: assert property (p_b_done) else $error("write not retired");
  property p_w_busy; o_bvalid |-> !o_awready && !o_wready; endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
  property p_strb;
    i_awvalid && o_awready && i_wvalid && o_wready && i_wstrb != 4'hF |-> ##2 o_bvalid && o_bresp == 2'h2;
  endproperty
  a_strb: assert property (p_strb) else $error("partial write not refused");
endmodule

bind fxst_status_regs fxst_status_regs_checker u_fxst_status_regs_checker (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
  .o_rresp(o_rresp));

// file: verif/fxst_bus_model.sv
// Software side register bus master issuing single AXI4-Lite word accesses.
`timescale 1ns/100ps

module fxst_bus_model (
  input  wire logic        i_ref_clk,
  output logic             o_awvalid,
  output logic [7:0]       o_awaddr,
  output logic             o_wvalid,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_wstrb,
  output logic             o_bready,
  output logic             o_arvalid,
  output logic [7:0]       o_araddr,
  output logic             o_rready,
  input  wire logic        i_awready,
  input  wire logic        i_wready,
  input  wire logic        i_bvalid,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_arready,
  input  wire logic        i_rvalid,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp
);
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    {o_awaddr, o_wdata, o_wstrb, o_araddr} = 52'h0;
  end
  // Released address and data lines show the inverse of the last value.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge i_ref_clk);
    {o_awvalid, o_awaddr, o_wvalid, o_wdata, o_wstrb, o_bready} <= {1'b1, a, 1'b1, d, s, 1'b1};
    while (!(ad && wd)) begin
      @(posedge i_ref_clk);
      if (!ad && i_awready) begin
        ad = 1'b1;
        {o_awvalid, o_awaddr} <= {1'b0, ~a};
      end
      if (!wd && i_wready) begin
        wd = 1'b1;
        {o_wvalid, o_wdata} <= {1'b0, ~d};
      end
    end
    do @(posedge i_ref_clk); while (!i_bvalid);
    r = i_bresp;
    o_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_ref_clk);
    {o_arvalid, o_araddr, o_rready} <= {1'b1, a, 1'b1};
    do @(posedge i_ref_clk); while (!i_arready);
    {o_arvalid, o_araddr} <= {1'b0, ~a};
    do @(posedge i_ref_clk); while (!i_rvalid);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
  endtask
endmodule

// file: verif/flexible_io_status_flags_tb_top.sv
// Testbench of the status flag bank: flags, pins, masks and requests over the bus.
`timescale 1ns/100ps

module flexible_io_status_flags_tb_top;
  logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [7:0]  awaddr, araddr, pins;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, dma;
  logic [1:0]  bresp, rresp, r;
  int          miscompares, checks;
  fxst_pkg::fxst_shifter_evt_t [3:0] sh;
  fxst_pkg::fxst_timer_evt_t   [3:0] tm;
  logic [7:0]  ofs [7] = '{8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h28};
  logic [7:0]  ien [3] = '{8'h18, 8'h1C, 8'h20};
  fxst_status_regs u_fxst_status_regs (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_pin_level_bits(pins), .i_shifter(sh), .i_timer(tm),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_awprot(3'h0),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .i_arprot(3'h0), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .o_irq(irq), .o_dma_req(dma));
  fxst_bus_model u_fxst_bus_model (
    .i_ref_clk(clk), .o_awvalid(awvalid), .o_awaddr(awaddr), .o_wvalid(wvalid),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_bready(bready), .o_arvalid(arvalid),
    .o_araddr(araddr), .o_rready(rready), .i_awready(awready), .i_wready(wready),
    .i_bvalid(bvalid), .i_bresp(bresp), .i_arready(arready), .i_rvalid(rvalid),
    .i_rdata(rdata), .i_rresp(rresp));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    u_fxst_bus_model.rd(a, d, r);
    cmp($sformatf("data at %h", a), e, d);
    cmp($sformatf("response at %h", a), 32'(er), 32'(r));
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                     input logic [1:0] er);
    u_fxst_bus_model.wr(a, v, s, r);
    cmp($sformatf("write response at %h", a), 32'(er), 32'(r));
  endtask
  // Pulses events of one shifter for a single cycle, then lets the flag land.
  task automatic ev(input int i, input logic [6:0] p);
    sh[i][6:0] <= p;
    @(posedge clk);
    sh[i][6:0] <= 7'h00;
    @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    pins = 8'hA5;
    sh = '0;
    miscompares = 0;
    checks = 0;
    tm[0] = {fxst_pkg::FXST_TMODE_BAUD8, 1'b1, 16'h0105};
    tm[1] = {fxst_pkg::FXST_TMODE_PWM8, 1'b1, 16'h0105};
    tm[2] = {fxst_pkg::FXST_TMODE_CNT16, 1'b1, 16'h0105};
    tm[3] = {fxst_pkg::FXST_TMODE_CNT16, 1'b0, 16'h0105};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ofs[k]) chk(ofs[k], 32'h0, 2'h0);
    chk(8'h04, 32'h000000A5, 2'h0);
    chk(8'h00, 32'h0, fxst_pkg::RESP_SLVERR);
    $display("test reset values done");
    sh[2].shifter_mode_sel <= fxst_pkg::FXST_SMODE_RX;
    sh[1].shifter_mode_sel <= fxst_pkg::FXST_SMODE_TX;
    @(posedge clk);
    ev(2, 7'h40);
    ev(3, 7'h40);
    chk(8'h08, 32'h6, 2'h0);
    ev(2, 7'h10);
    ev(1, 7'h08);
    chk(8'h08, 32'h0, 2'h0);
    ev(1, 7'h20);
    chk(8'h08, 32'h2, 2'h0);
    put(8'h08, 32'h2, 4'hF, 2'h0);
    chk(8'h08, 32'h0, 2'h0);
    ev(1, 7'h20);
    $display("test ready flags done");
    sh[0].shifter_mode_sel <= fxst_pkg::FXST_SMODE_RX;
    @(posedge clk);
    ev(0, 7'h04);
    ev(2, 7'h02);
    ev(1, 7'h01);
    ev(3, 7'h7F);
    chk(8'h0C, 32'h7, 2'h0);
    put(8'h0C, 32'h5, 4'hF, 2'h0);
    put(8'h0C, 32'hF, 4'h3, fxst_pkg::RESP_SLVERR);
    chk(8'h0C, 32'h2, 2'h0);
    // The overrun pulse lands on the very edge at which the write-one clear acts.
    fork
      put(8'h0C, 32'h1, 4'hF, 2'h0);
      begin
        repeat (2) @(posedge clk);
        ev(0, 7'h04);
      end
    join
    chk(8'h0C, 32'h3, 2'h0);
    $display("test fault flags done");
    for (int i = 0; i < 4; i++) tm[i].count <= 16'h0005;
    repeat (2) @(posedge clk);
    chk(8'h10, 32'h3, 2'h0);
    tm[2].count <= 16'h0000;
    tm[3].count <= 16'h0000;
    @(posedge clk);
    chk(8'h10, 32'h7, 2'h0);
    tm[3] <= {fxst_pkg::FXST_TMODE_OFF, 1'b1, 16'h0001};
    @(posedge clk);
    tm[3].count <= 16'h0000;
    @(posedge clk);
    chk(8'h10, 32'h7, 2'h0);
    $display("test timer flags done");
    foreach (ien[k]) begin
      put(ien[k], 32'hFFFFFFFF, 4'hF, 2'h0);
      chk(ien[k], 32'hF, 2'h0);
      @(negedge clk);
      cmp("irq enabled", 32'h1, 32'(irq));
      put(ien[k], 32'h0, 4'hF, 2'h0);
      @(negedge clk);
      cmp("irq masked", 32'h0, 32'(irq));
    end
    put(8'h20, 32'hF, 4'hF, 2'h0);
    put(8'h10, 32'h7, 4'hF, 2'h0);
    @(negedge clk);
    cmp("irq cleared", 32'h0, 32'(irq));
    cmp("dma idle", 32'h0, 32'(dma));
    put(8'h28, 32'hF, 4'hF, 2'h0);
    @(negedge clk);
    cmp("dma request", 32'h2, 32'(dma));
    $display("test interrupt and dma done");
    summarize();
  end
endmodule
